/* wdc_watchdog.sv */
// Watchdog built on a 32-bit down-counter with interrupt and reset request.
// Assumes the count clock is this same clock; control bits are plain ports.
//
// Notes on behaviour
// - 32-bit down-counter loaded from reload value
// - Enabled: decrement by one each tick
// - Interrupt raised each time countdown expires
// - Zero with interrupt pending: reset request, stop
// - After stop, reload next enabled tick, continue
// - Reset request again if interrupt still uncleared
// - Disabled unit neither counts nor signals
// - Lock blocks disable and reconfiguration writes
// - Count clock synchronous to bus clock
`include "wdc_consts.svh"

module wdc_watchdog #(
	parameter int CNT_W = `WDC_CNT_W
) (
	input wire logic SYS_CLK,
	input wire logic RST,
	input wire logic CNT_TICK,
	input wire logic ENABLE_WR,
	input wire logic ENABLE_WDATA,
	input wire logic RELOAD_WR,
	input wire logic [CNT_W-1:0] RELOAD_WDATA,
	input wire logic INT_CLEAR,
	input wire logic LOCK_WR,
	input wire logic [31:0] LOCK_WDATA,
	output logic [CNT_W-1:0] COUNT_VALUE,
	output logic [CNT_W-1:0] RELOAD_VALUE,
	output logic ENABLED,
	output logic LOCKED,
	output logic WDT_INT,
	output logic RESET_REQ
);

	typedef struct packed {
		logic [CNT_W-1:0] cnt;
		logic [CNT_W-1:0] reload;
		logic en;
		logic irq;
		logic rst_req;
		logic locked;
		wdc_pkg::wdc_phase_t phase;
	} wdc_state_t;

	wdc_state_t s_q;
	wdc_state_t s_d;
	logic lock_now;

	// ----------------------------------------
	// Lock register
	// ----------------------------------------
	wdc_lock u_lock (
		.clk(SYS_CLK),
		.rst(RST),
		.lock_wr(LOCK_WR),
		.lock_wdata(LOCK_WDATA),
		.locked(lock_now)
	);

	// ----------------------------------------
	// Next-state logic
	// ----------------------------------------
	// Tick is a plain enable on SYS_CLK, so no crossing logic is needed
	always_comb begin
		s_d = s_q;
		s_d.locked = lock_now;
		// Configuration writes only pass while unlocked
		if (!lock_now && ENABLE_WR) begin
			s_d.en = ENABLE_WDATA;
		end
		if (!lock_now && RELOAD_WR) begin
			s_d.reload = RELOAD_WDATA;
		end
		if (!s_d.en) begin
			// Disabled: load count from reload, drop outputs
			s_d.phase = wdc_pkg::WDC_IDLE;
			s_d.irq = 1'b0;
			s_d.rst_req = 1'b0;
			s_d.cnt = s_d.reload;
		end else begin
			case (s_q.phase)
				wdc_pkg::WDC_IDLE: begin
					s_d.cnt = s_d.reload;
					s_d.phase = wdc_pkg::WDC_RUN;
				end
				// Expiry is the tick seen at zero, so a period is reload plus one ticks
				wdc_pkg::WDC_RUN: begin
					if (CNT_TICK) begin
						if (s_q.cnt == `WDC_CNT_ZERO) begin
							s_d.irq = 1'b1;
							if (s_q.irq && !INT_CLEAR) begin
								// Pending at zero: request reset and stop
								s_d.rst_req = 1'b1;
								s_d.phase = wdc_pkg::WDC_STOP;
							end else begin
								s_d.cnt = s_d.reload;
							end
						end else begin
							s_d.cnt = s_q.cnt - CNT_W'(1);
						end
					end
				end
				wdc_pkg::WDC_STOP: begin
					if (CNT_TICK) begin
						// Reload and continue; reset request drops
						s_d.cnt = s_d.reload;
						s_d.rst_req = 1'b0;
						s_d.phase = wdc_pkg::WDC_RUN;
					end
				end
				default: begin
					s_d.phase = wdc_pkg::WDC_IDLE;
				end
			endcase
			// Clear loses to an expiry in the same cycle
			if (INT_CLEAR && !(CNT_TICK && s_q.cnt == `WDC_CNT_ZERO
					&& s_q.phase == wdc_pkg::WDC_RUN)) begin
				s_d.irq = 1'b0;
				s_d.cnt = s_d.reload;
				if (s_q.phase == wdc_pkg::WDC_STOP) begin
					s_d.phase = wdc_pkg::WDC_RUN;
					s_d.rst_req = 1'b0;
				end
			end
		end
	end

	// ----------------------------------------
	// State register
	// ----------------------------------------
	always_ff @(posedge SYS_CLK or posedge RST) begin
		if (RST) begin
			s_q <= '{cnt: CNT_W'(`WDC_RELOAD_RST), reload: CNT_W'(`WDC_RELOAD_RST),
				en: 1'b0, irq: 1'b0, rst_req: 1'b0, locked: 1'b1,
				phase: wdc_pkg::WDC_IDLE};
		end else begin
			s_q <= s_d;
		end
	end

	// Outputs straight from flip-flops
	assign COUNT_VALUE = s_q.cnt;
	assign RELOAD_VALUE = s_q.reload;
	assign ENABLED = s_q.en;
	assign LOCKED = s_q.locked;
	assign WDT_INT = s_q.irq;
	assign RESET_REQ = s_q.rst_req;

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	// In run without a clear, count moves only on a tick, and then by exactly one above zero
	a_cnt_decrements: assert property (@(posedge SYS_CLK) disable iff (RST)
		s_q.phase == wdc_pkg::WDC_RUN && s_q.en && CNT_TICK && s_q.cnt != 0
		&& !INT_CLEAR && !ENABLE_WR |=> COUNT_VALUE == $past(COUNT_VALUE) - 1)
		else $error("counter did not step down by one");
	a_count_holds: assert property (@(posedge SYS_CLK) disable iff (RST)
		ENABLED && s_q.phase == wdc_pkg::WDC_RUN && !CNT_TICK && !INT_CLEAR
		&& !ENABLE_WR |=> COUNT_VALUE == $past(COUNT_VALUE))
		else $error("counter moved without tick");

	// Expiry, stop and resume around zero
	a_irq_on_expiry: assert property (@(posedge SYS_CLK) disable iff (RST)
		s_q.phase == wdc_pkg::WDC_RUN && s_q.en && CNT_TICK && s_q.cnt == 0
		&& !ENABLE_WR |=> WDT_INT)
		else $error("interrupt missing at expiry");
	a_reset_req_stop: assert property (@(posedge SYS_CLK) disable iff (RST)
		s_q.phase == wdc_pkg::WDC_RUN && s_q.en && CNT_TICK && s_q.cnt == 0
		&& WDT_INT && !INT_CLEAR && !ENABLE_WR |=> RESET_REQ && COUNT_VALUE == 0)
		else $error("no reset request at zero with interrupt pending");
	a_stop_holds: assert property (@(posedge SYS_CLK) disable iff (RST)
		s_q.phase == wdc_pkg::WDC_STOP && s_q.en && !CNT_TICK && !INT_CLEAR
		&& !ENABLE_WR |=> RESET_REQ && COUNT_VALUE == 0)
		else $error("stopped counter moved or dropped request");
	a_req_only_stopped: assert property (@(posedge SYS_CLK) disable iff (RST)
		RESET_REQ |-> s_q.phase == wdc_pkg::WDC_STOP)
		else $error("reset request outside stop phase");
	a_stop_reload: assert property (@(posedge SYS_CLK) disable iff (RST)
		s_q.phase == wdc_pkg::WDC_STOP && s_q.en && CNT_TICK && !ENABLE_WR
		&& !RELOAD_WR |=> COUNT_VALUE == RELOAD_VALUE && !RESET_REQ)
		else $error("stopped counter not reloaded");
	a_req_needs_irq: assert property (@(posedge SYS_CLK) disable iff (RST)
		$rose(RESET_REQ) |-> $past(WDT_INT))
		else $error("reset request without pending interrupt");

	// Disabled unit stays idle and silent
	a_disabled_quiet: assert property (@(posedge SYS_CLK) disable iff (RST)
		!ENABLED |-> !WDT_INT && !RESET_REQ)
		else $error("disabled unit signalled");
	a_idle_when_off: assert property (@(posedge SYS_CLK) disable iff (RST)
		!ENABLED |-> s_q.phase == wdc_pkg::WDC_IDLE && COUNT_VALUE == RELOAD_VALUE)
		else $error("disabled unit not idle at reload value");

	// Lock gates configuration; open writes land on the next edge
	a_lock_blocks: assert property (@(posedge SYS_CLK) disable iff (RST)
		LOCKED && lock_now |=> ENABLED == $past(ENABLED)
		&& RELOAD_VALUE == $past(RELOAD_VALUE))
		else $error("write passed while locked");
	a_write_lands: assert property (@(posedge SYS_CLK) disable iff (RST)
		!lock_now && ENABLE_WR |=> ENABLED == $past(ENABLE_WDATA))
		else $error("open enable write was lost");
	a_reload_lands: assert property (@(posedge SYS_CLK) disable iff (RST)
		!lock_now && RELOAD_WR |=> RELOAD_VALUE == $past(RELOAD_WDATA))
		else $error("open reload write was lost");

	// Software clear drops the interrupt and restarts the count
	a_clear_reloads: assert property (@(posedge SYS_CLK) disable iff (RST)
		INT_CLEAR && s_q.en && !CNT_TICK && !ENABLE_WR && !RELOAD_WR
		|=> !WDT_INT && COUNT_VALUE == RELOAD_VALUE)
		else $error("clear did not drop interrupt and reload");
	a_clear_exits_stop: assert property (@(posedge SYS_CLK) disable iff (RST)
		s_q.phase == wdc_pkg::WDC_STOP && s_q.en && INT_CLEAR && !ENABLE_WR
		|=> !RESET_REQ && !WDT_INT)
		else $error("clear did not leave stop phase");

	// ----------------------------------------
	// Coverage of the main scenarios
	// ----------------------------------------
	c_expiry: cover property (@(posedge SYS_CLK) disable iff (RST) $rose(WDT_INT));
	c_reset_req: cover property (@(posedge SYS_CLK) disable iff (RST) $rose(RESET_REQ));
	c_resume: cover property (@(posedge SYS_CLK) disable iff (RST) $fell(RESET_REQ) && ENABLED);
	c_unlock: cover property (@(posedge SYS_CLK) disable iff (RST) $fell(LOCKED));
	// Clear and expiry in one cycle, where the expiry must win
	c_clear_tie: cover property (@(posedge SYS_CLK) disable iff (RST)
		s_q.phase == wdc_pkg::WDC_RUN && s_q.en && CNT_TICK && s_q.cnt == 0 && INT_CLEAR);

endmodule : wdc_watchdog

/* wdc_consts.svh */
// Constants for the watchdog down-counter block.
// Assumes inclusion by its bare name from the package and design files.
`ifndef WDC_CONSTS_SVH
`define WDC_CONSTS_SVH

// ----------------------------------------
// Widths and reset values
// ----------------------------------------
`define WDC_CNT_W 32
`define WDC_RELOAD_RST 32'hffffffff
// Unlock key; the value is arbitrary
`define WDC_UNLOCK_KEY 32'h5a5a0f0f
`define WDC_CNT_ZERO 32'h00000000

// ----------------------------------------
// Timing counts
// ----------------------------------------
`define WDC_RLD_LAT_CYC 1

`endif

/* wdc_pkg.sv */
// Types shared by the watchdog down-counter design files.
// Assumes wdc_consts.svh sits in the same folder.
`include "wdc_consts.svh"

package wdc_pkg;

	// ----------------------------------------
	// Counter phase
	// ----------------------------------------
	typedef enum logic [1:0] {
		WDC_IDLE = 2'b00,
		WDC_RUN = 2'b01,
		WDC_STOP = 2'b10
	} wdc_phase_t;

	// ----------------------------------------
	// Lock register state
	// ----------------------------------------
	typedef struct packed {
		logic locked;
	} wdc_lock_st_t;

endpackage : wdc_pkg

/* wdc_lock.sv */
// Lock register of the watchdog: guards configuration writes.
// Assumes a single clock shared with the counter logic.
`include "wdc_consts.svh"

module wdc_lock (
	input wire logic clk,
	input wire logic rst,
	input wire logic lock_wr,
	input wire logic [31:0] lock_wdata,
	output logic locked
);

	wdc_pkg::wdc_lock_st_t st_q;
	wdc_pkg::wdc_lock_st_t st_d;

	// Key opens, any other value closes again
	always_comb begin
		st_d = st_q;
		if (lock_wr) begin
			st_d.locked = (lock_wdata != `WDC_UNLOCK_KEY);
		end
	end

	// Locked from reset so stray writes are blocked at once
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			st_q <= '{locked: 1'b1};
		end else begin
			st_q <= st_d;
		end
	end

	assign locked = st_q.locked;

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	a_lock_key_opens: assert property (@(posedge clk) disable iff (rst)
		lock_wr && lock_wdata == `WDC_UNLOCK_KEY |=> !locked)
		else $error("lock did not open on key");
	a_lock_other_closes: assert property (@(posedge clk) disable iff (rst)
		lock_wr && lock_wdata != `WDC_UNLOCK_KEY |=> locked)
		else $error("lock did not close on wrong value");

endmodule : wdc_lock

/* watchdog_down_counter_bench.sv */
// Self-checking bench for the watchdog down-counter block.
// Assumes wdc_consts.svh and the design files are compiled alongside.
`include "wdc_consts.svh"

module watchdog_down_counter_bench;
	timeunit 1ns;
	timeprecision 1ps;

	// --------------------------------
	// Stimulus and observed signals
	// --------------------------------
	localparam logic [31:0] N = 32'h00000003;
	typedef struct packed {
		logic t;
		logic c;
		logic [31:0] cnt;
		logic i;
		logic r;
	} wdc_row_t;
	logic sys_clk = 1'b0;
	logic rst = 1'b1;
	logic tick = 1'b0;
	logic en_wr = 1'b0;
	logic en_d = 1'b0;
	logic rl_wr = 1'b0;
	logic clr = 1'b0;
	logic lk_wr = 1'b0;
	logic [31:0] wd = 32'h00000000;
	logic [31:0] cnt;
	logic [31:0] rld;
	logic enabled;
	logic locked;
	logic w_int;
	logic req;
	int error_cnt = 0;
	int num_checks = 0;
	// Tick, clear, then expected count, interrupt, reset request
	wdc_row_t rows [12] = '{
		'{1'b1, 1'b0, 32'h2, 1'b0, 1'b0}, '{1'b1, 1'b0, 32'h1, 1'b0, 1'b0},
		'{1'b1, 1'b0, 32'h0, 1'b0, 1'b0}, '{1'b1, 1'b0, 32'h3, 1'b1, 1'b0},
		'{1'b0, 1'b0, 32'h3, 1'b1, 1'b0}, '{1'b1, 1'b0, 32'h2, 1'b1, 1'b0},
		'{1'b1, 1'b0, 32'h1, 1'b1, 1'b0}, '{1'b1, 1'b0, 32'h0, 1'b1, 1'b0},
		'{1'b1, 1'b0, 32'h0, 1'b1, 1'b1}, '{1'b1, 1'b0, 32'h3, 1'b1, 1'b0},
		'{1'b0, 1'b1, 32'h3, 1'b0, 1'b0}, '{1'b1, 1'b0, 32'h2, 1'b0, 1'b0}};

	always #20 sys_clk = ~sys_clk;

	wdc_watchdog dut (
		.SYS_CLK(sys_clk), .RST(rst), .CNT_TICK(tick), .ENABLE_WR(en_wr),
		.ENABLE_WDATA(en_d), .RELOAD_WR(rl_wr), .RELOAD_WDATA(wd), .INT_CLEAR(clr),
		.LOCK_WR(lk_wr), .LOCK_WDATA(wd), .COUNT_VALUE(cnt), .RELOAD_VALUE(rld),
		.ENABLED(enabled), .LOCKED(locked), .WDT_INT(w_int), .RESET_REQ(req)
	);

	// --------------------------------
	// Shared tasks
	// --------------------------------
	task chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp) begin
			error_cnt++;
			$display("Error %s expected %h seen %h", what, exp, seen);
		end
	endtask : chk

	task close_out;
		$display("Checks %0d errors %0d", num_checks, error_cnt);
		if (error_cnt == 0 && num_checks > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask : close_out

	// One-cycle strobes; flags are enable write, enable value, reload, lock, tick, clear
	task drive(input logic [5:0] f, input logic [31:0] d);
		@(posedge sys_clk);
		{en_wr, en_d, rl_wr, lk_wr, tick, clr} <= f;
		wd <= d;
		@(posedge sys_clk);
		{en_wr, en_d, rl_wr, lk_wr, tick, clr} <= 6'b000000;
		@(negedge sys_clk);
	endtask : drive

	// Locked port lags the internal lock by one edge
	task cfg(input logic [5:0] f, input logic [31:0] d);
		drive(f, d);
		repeat (2) @(negedge sys_clk);
	endtask : cfg

	// Plain count ticks, one strobe each
	task ticks(input int n);
		for (int j = 0; j < n; j++) begin
			drive(6'b000010, 32'h0);
		end
	endtask : ticks

	// Hang guard: a bounded run that ends in the same report
	initial begin
		repeat (5000) @(posedge sys_clk);
		error_cnt++;
		close_out();
	end

	// --------------------------------
	// Main sequence
	// --------------------------------
	initial begin
		repeat (3) @(posedge sys_clk);
		rst <= 1'b0;
		@(negedge sys_clk);
		chk("count", cnt, `WDC_RELOAD_RST);
		chk("locked", 32'(locked), 32'h1);
		cfg(6'b110000, 32'h0);
		chk("enabled", 32'(enabled), 32'h0);
		cfg(6'b000100, `WDC_UNLOCK_KEY);
		chk("locked", 32'(locked), 32'h0);
		cfg(6'b111000, N);
		chk("reload", rld, N);
		chk("count", cnt, N);
		// Table walks decrement, expiry, stop at zero, reload and clear
		foreach (rows[k]) begin
			drive({4'b0000, rows[k].t, rows[k].c}, 32'h0);
			chk("count", cnt, rows[k].cnt);
			chk("irq", 32'(w_int), 32'(rows[k].i));
			chk("rstreq", 32'(req), 32'(rows[k].r));
		end
		// Expiry, then a stop at the next zero
		ticks(7);
		chk("rstreq", 32'(req), 32'h1);
		chk("count", cnt, 32'h0);
		// Resume with the interrupt still pending: request comes back
		ticks(5);
		chk("rstreq", 32'(req), 32'h1);
		chk("irq", 32'(w_int), 32'h1);
		// Clear while stopped drops both outputs and restarts from reload
		drive(6'b000001, 32'h0);
		chk("count", cnt, N);
		chk("irq", 32'(w_int), 32'h0);
		chk("rstreq", 32'(req), 32'h0);
		// Clear and expiry in one cycle: the expiry wins
		ticks(3);
		drive(6'b000011, 32'h0);
		chk("irq", 32'(w_int), 32'h1);
		chk("count", cnt, N);
		chk("rstreq", 32'(req), 32'h0);
		// Any non-key value relocks; guarded writes then drop silently
		cfg(6'b000100, 32'h00000005);
		chk("locked", 32'(locked), 32'h1);
		cfg(6'b101000, 32'h00000009);
		chk("enabled", 32'(enabled), 32'h1);
		chk("reload", rld, N);
		cfg(6'b000100, `WDC_UNLOCK_KEY);
		cfg(6'b100000, 32'h0);
		chk("enabled", 32'(enabled), 32'h0);
		drive(6'b000010, 32'h0);
		chk("count", cnt, N);
		chk("irq", 32'(w_int), 32'h0);
		chk("rstreq", 32'(req), 32'h0);
		// Second reset while disabled restores the locked idle state
		@(posedge sys_clk);
		rst <= 1'b1;
		@(negedge sys_clk);
		chk("locked", 32'(locked), 32'h1);
		chk("reload", rld, `WDC_RELOAD_RST);
		@(posedge sys_clk);
		rst <= 1'b0;
		// Two edges after release: still idle and quiet
		repeat (2) @(negedge sys_clk);
		chk("enabled", 32'(enabled), 32'h0);
		chk("count", cnt, `WDC_RELOAD_RST);
		chk("irq", 32'(w_int), 32'h0);
		// Lock is closed again, so an enable write is dropped
		cfg(6'b110000, 32'h0);
		chk("enabled", 32'(enabled), 32'h0);
		close_out();
	end
endmodule : watchdog_down_counter_bench
